// ---- design/eeprom_wp_pkg.sv ----
// Operation
// RULE1 - no array or status write begins unless the write latch is set
// RULE2 - set-latch command sets the latch, clear-latch command clears it
// RULE3 - latch clears at reset and after clear, status write or array write
// RULE4 - status read is accepted any time, also during a write cycle
// RULE5 - status byte: pin enable 7, unused 6..4, selects 3..2, latch 1, busy 0
// RULE6 - busy reads 1 during an internal write cycle; bus writes never touch it
// RULE7 - latch bit mirrors latch, read-only, always set/cleared by its commands
// RULE8 - protection selects are kept and change only by a good status write
// RULE9 - status write updates only pin enable and the two selects
// RULE10 - selects 00 none, 01 3000h-3FFFh, 10 2000h-3FFFh, 11 all protected
// RULE11 - hardware protection is on exactly when pin low and pin enable is 1
// RULE12 - hardware protection blocks only status writes, nothing else
// RULE13 - latch clear: nothing writable; set: free blocks, status unless locked
// RULE14 - write cycle starts only if chip select rises after exact bit count
// RULE15 - array access during a write cycle is ignored, cycle runs to its end
// RULE16 - reset: standby, latch clear, output off, needs select fall to start
// RULE17 - opcodes 06h set, 04h clear, 05h status read, 01h status write
// RULE18 - latch sets only on the select rise after the eighth bit
// RULE19 - a later fall of the protect pin leaves a running cycle alone
// RULE20 - bits travel msb first, inputs sampled on rising serial clock
// RULE21 - unused status bits read zero and ignore written data
// RULE22 - status read repeats the current byte while clocking continues
package eeprom_wp_pkg;

    // ----------------------------------------------------------------
    // instruction codes
    // ----------------------------------------------------------------
    localparam logic [7:0] OP_SET_LATCH    = 8'h06;
    localparam logic [7:0] OP_CLEAR_LATCH  = 8'h04;
    localparam logic [7:0] OP_STATUS_READ  = 8'h05;
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_ARRAY_WRITE  = 8'h02;

    // ----------------------------------------------------------------
    // frame lengths in whole bytes, and the last bit index of a byte
    // ----------------------------------------------------------------
    localparam logic [2:0] CMD_BYTES       = 3'h1;
    localparam logic [2:0] STAT_WR_BYTES   = 3'h2;
    localparam logic [2:0] ARR_WR_MIN      = 3'h4;
    localparam logic [2:0] BYTE_CNT_MAX    = 3'h7;
    localparam logic [2:0] LAST_BIT        = 3'h7;

    // ----------------------------------------------------------------
    // array geometry and protection limits
    // ----------------------------------------------------------------
    localparam int         ADDR_W          = 14;
    localparam logic [13:0] QUARTER_BASE   = 14'h3000;
    localparam logic [13:0] HALF_BASE      = 14'h2000;

    // ----------------------------------------------------------------
    // reset values and timing
    // ----------------------------------------------------------------
    localparam logic       PIN_EN_RST      = 1'h0;
    localparam logic [1:0] SEL_RST         = 2'h0;
    localparam logic       LATCH_RST       = 1'h0;
    localparam logic [3:0] PINS_RST        = 4'h9;
    localparam logic [1:0] FLUSH_EDGES     = 2'h2;
    localparam int         WRITE_CYCLES    = 1024;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       pin_en;
        logic [2:0] unused;
        logic [1:0] sel;
        logic       latch;
        logic       busy;
    } status_s;

    typedef struct packed {
        logic              start;
        logic [ADDR_W-1:0] addr;
    } array_wr_s;

    function automatic logic is_protected(input logic [1:0] sel,
                                          input logic [13:0] addr);
        unique case (sel)
            2'h0: is_protected = 1'b0;
            2'h1: is_protected = (addr >= QUARTER_BASE);
            2'h2: is_protected = (addr >= HALF_BASE);
            2'h3: is_protected = 1'b1;
        endcase
    endfunction : is_protected

endpackage : eeprom_wp_pkg

// ---- design/pin_sync.sv ----
`timescale 1ns/100ps
module pin_sync #(
    parameter int         W       = 4,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         ref_clk_i,
    input  wire logic         arst_n_i,
    input  wire logic [W-1:0] pin_i,
    output logic      [W-1:0] level_o,
    output logic      [W-1:0] rise_o,
    output logic      [W-1:0] fall_o
);

    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;
    logic [W-1:0] prev_q;

    // ----------------------------------------------------------------
    // two-stage crossing plus one stage for edges
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
            prev_q <= RST_VAL;
        end else begin
            meta_q <= pin_i;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    always_comb begin
        level_o = sync_q;
        rise_o  = sync_q & ~prev_q;
        fall_o  = ~sync_q & prev_q;
    end

endmodule : pin_sync

// ---- design/spi_eeprom_write_protect.sv ----
`timescale 1ns/100ps
module spi_eeprom_write_protect
    import eeprom_wp_pkg::*;
#(
    parameter int WRITE_CYCLES_P = eeprom_wp_pkg::WRITE_CYCLES
) (
    input  wire logic                   ref_clk_i,
    input  wire logic                   arst_n_i,
    input  wire logic                   cs_n_i,
    input  wire logic                   sck_i,
    input  wire logic                   si_i,
    input  wire logic                   wp_n_i,
    output logic                        so_o,
    output logic                        so_oe_o,
    output eeprom_wp_pkg::status_s      status_o,
    output eeprom_wp_pkg::array_wr_s    array_wr_o,
    output logic                        busy_o
);
    import eeprom_wp_pkg::*;

    localparam int TW = $clog2(WRITE_CYCLES_P + 1);
    localparam logic [TW-1:0] TIMER_LOAD = TW'(WRITE_CYCLES_P);

    typedef enum logic {IDLE, ACTIVE} phase_e;

    // ----------------------------------------------------------------
    // pin crossing
    // ----------------------------------------------------------------
    logic [3:0] pin_lvl;
    logic [3:0] pin_rise;
    logic [3:0] pin_fall;

    pin_sync #(
        .W       (4),
        .RST_VAL (PINS_RST)
    ) u_pin_sync (
        .ref_clk_i (ref_clk_i),
        .arst_n_i  (arst_n_i),
        .pin_i     ({wp_n_i, si_i, sck_i, cs_n_i}),
        .level_o   (pin_lvl),
        .rise_o    (pin_rise),
        .fall_o    (pin_fall)
    );

    logic cs_high;
    logic cs_rise;
    logic cs_fall;
    logic sck_rise;
    logic sck_fall;
    logic si_lvl;
    logic wp_high;

    assign cs_high  = pin_lvl[0];
    assign cs_rise  = pin_rise[0];
    assign cs_fall  = pin_fall[0];
    assign sck_rise = pin_rise[1];
    assign sck_fall = pin_fall[1];
    assign si_lvl   = pin_lvl[2];
    assign wp_high  = pin_lvl[3];

    // ----------------------------------------------------------------
    // start-up flush
    // ----------------------------------------------------------------
    // the synchroniser shows its reset value for two edges; a select
    // level seen before then is not the pin's and must not arm a frame
    logic [1:0] flush_q;
    logic [1:0] flush_d;
    logic       flushed;

    assign flushed = (flush_q == FLUSH_EDGES);

    always_comb begin
        flush_d = flushed ? flush_q : flush_q + 2'h1;
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            flush_q <= 2'h0;
        end else begin
            flush_q <= flush_d;
        end
    end

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    phase_e            phase_q,    phase_d;
    logic              armed_q,    armed_d;
    logic [7:0]        shift_q,    shift_d;
    logic [2:0]        bit_idx_q,  bit_idx_d;
    logic [2:0]        byte_cnt_q, byte_cnt_d;
    logic [7:0]        opcode_q,   opcode_d;
    logic [7:0]        byte1_q,    byte1_d;
    logic [7:0]        byte2_q,    byte2_d;
    logic [7:0]        out_q,      out_d;
    logic              so_q,       so_d;
    logic              so_oe_q,    so_oe_d;
    logic              latch_q,    latch_d;
    logic              pin_en_q,   pin_en_d;
    logic [1:0]        sel_q,      sel_d;
    logic [TW-1:0]     timer_q,    timer_d;
    logic              wr_start_q, wr_start_d;
    logic [ADDR_W-1:0] wr_addr_q,  wr_addr_d;

    logic              busy;
    logic              hw_locked;
    logic              frame_whole;
    logic [7:0]        byte_in;
    logic [ADDR_W-1:0] frame_addr;
    status_s           status;

    assign busy        = (timer_q != '0);
    assign hw_locked   = pin_en_q && !wp_high;         // see RULE11
    assign frame_whole = (bit_idx_q == '0);
    assign byte_in     = {shift_q[6:0], si_lvl};
    assign frame_addr  = {byte1_q[5:0], byte2_q};

    // ----------------------------------------------------------------
    // frame length checks
    // ----------------------------------------------------------------
    // exact length or the command is dropped (see RULE14)
    function automatic logic ends_on(input logic [2:0] cnt,
                                     input logic [2:0] idx,
                                     input logic [2:0] want);
        ends_on = (cnt == want) && (idx == 3'h0);
    endfunction : ends_on

    logic              cmd_whole;
    logic              stat_whole;
    logic              arr_whole;
    logic              rd_active;

    assign cmd_whole  = ends_on(byte_cnt_q, bit_idx_q, CMD_BYTES);
    assign stat_whole = ends_on(byte_cnt_q, bit_idx_q, STAT_WR_BYTES);
    assign arr_whole  = (byte_cnt_q >= ARR_WR_MIN) && frame_whole;
    assign rd_active  = (byte_cnt_q >= CMD_BYTES)
                        && (opcode_q == OP_STATUS_READ);

    // ----------------------------------------------------------------
    // status byte assembly
    // ----------------------------------------------------------------
    always_comb begin
        status.pin_en = pin_en_q;                      // see RULE5
        status.unused = 3'h0;                          // see RULE21
        status.sel    = sel_q;
        status.latch  = latch_q;                       // see RULE7
        status.busy   = busy;                          // see RULE6
    end

    // ----------------------------------------------------------------
    // serial protocol and protection
    // ----------------------------------------------------------------
    always_comb begin
        phase_d    = phase_q;
        armed_d    = armed_q | (cs_high && flushed);
        shift_d    = shift_q;
        bit_idx_d  = bit_idx_q;
        byte_cnt_d = byte_cnt_q;
        opcode_d   = opcode_q;
        byte1_d    = byte1_q;
        byte2_d    = byte2_q;
        out_d      = out_q;
        so_d       = so_q;
        so_oe_d    = so_oe_q;
        latch_d    = latch_q;
        pin_en_d   = pin_en_q;
        sel_d      = sel_q;
        timer_d    = busy ? timer_q - TW'(1) : timer_q;
        wr_start_d = 1'b0;
        wr_addr_d  = wr_addr_q;

        unique case (phase_q)
            IDLE: begin
                // a select held low since reset never opens a frame
                if (cs_fall && armed_q) begin          // see RULE16
                    phase_d    = ACTIVE;
                    bit_idx_d  = '0;
                    byte_cnt_d = '0;
                    opcode_d   = 8'h00;
                end
            end
            ACTIVE: begin
                if (sck_rise) begin                    // see RULE20
                    shift_d   = byte_in;
                    bit_idx_d = bit_idx_q + 3'h1;
                    if (bit_idx_q == LAST_BIT) begin
                        unique case (byte_cnt_q)
                            3'h0:    opcode_d = byte_in;
                            3'h1:    byte1_d  = byte_in;
                            3'h2:    byte2_d  = byte_in;
                            default: ;
                        endcase
                        if (byte_cnt_q != BYTE_CNT_MAX) begin
                            byte_cnt_d = byte_cnt_q + 3'h1;
                        end
                    end
                end
                // status shifts out after each falling clock, reloaded
                // at every byte boundary so the busy bit stays live
                if (sck_fall && rd_active) begin       // see RULE4
                    so_oe_d = 1'b1;
                    if (frame_whole) begin             // see RULE22
                        so_d  = status[7];
                        out_d = {status[6:0], 1'b0};
                    end else begin
                        so_d  = out_q[7];
                        out_d = {out_q[6:0], 1'b0};
                    end
                end
                if (cs_rise) begin
                    phase_d = IDLE;
                    so_oe_d = 1'b0;
                    unique case (opcode_q)             // see RULE17
                        OP_SET_LATCH: begin
                            if (cmd_whole) begin
                                latch_d = 1'b1;        // see RULE2, RULE18
                            end
                        end
                        OP_CLEAR_LATCH: begin
                            if (cmd_whole) begin
                                latch_d = 1'b0;        // see RULE2, RULE3
                            end
                        end
                        OP_STATUS_WRITE: begin
                            if (stat_whole
                                && latch_q            // see RULE1, RULE13
                                && !hw_locked         // see RULE12
                                && !busy) begin       // see RULE14
                                pin_en_d = byte1_q[7]; // see RULE9
                                sel_d    = byte1_q[3:2]; // see RULE8
                                latch_d  = 1'b0;       // see RULE3
                                timer_d  = TIMER_LOAD; // see RULE6
                            end
                        end
                        OP_ARRAY_WRITE: begin
                            // page stays inside one quarter, so the start
                            // address decides protection for all bytes
                            if (arr_whole
                                && latch_q            // see RULE1, RULE13
                                && !busy              // see RULE15
                                && !is_protected(sel_q,
                                                 frame_addr)) begin
                                wr_start_d = 1'b1;     // see RULE10, RULE14
                                wr_addr_d  = frame_addr;
                                latch_d    = 1'b0;     // see RULE3
                                timer_d    = TIMER_LOAD;
                            end
                        end
                        default: ;
                    endcase
                end
            end
        endcase
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    // running cycle depends only on the timer, so the protect pin
    // cannot cut it short once loaded (see RULE19)
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            phase_q    <= IDLE;
            armed_q    <= 1'b0;
            shift_q    <= 8'h00;
            bit_idx_q  <= 3'h0;
            byte_cnt_q <= 3'h0;
            opcode_q   <= 8'h00;
            byte1_q    <= 8'h00;
            byte2_q    <= 8'h00;
            out_q      <= 8'h00;
            so_q       <= 1'b0;
            so_oe_q    <= 1'b0;
            latch_q    <= LATCH_RST;                   // see RULE3, RULE16
            pin_en_q   <= PIN_EN_RST;
            sel_q      <= SEL_RST;
            timer_q    <= '0;
            wr_start_q <= 1'b0;
            wr_addr_q  <= '0;
        end else begin
            phase_q    <= phase_d;
            armed_q    <= armed_d;
            shift_q    <= shift_d;
            bit_idx_q  <= bit_idx_d;
            byte_cnt_q <= byte_cnt_d;
            opcode_q   <= opcode_d;
            byte1_q    <= byte1_d;
            byte2_q    <= byte2_d;
            out_q      <= out_d;
            so_q       <= so_d;
            so_oe_q    <= so_oe_d;
            latch_q    <= latch_d;
            pin_en_q   <= pin_en_d;
            sel_q      <= sel_d;
            timer_q    <= timer_d;
            wr_start_q <= wr_start_d;
            wr_addr_q  <= wr_addr_d;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign so_o             = so_q;
    assign so_oe_o          = so_oe_q;
    assign status_o         = status;
    assign array_wr_o.start = wr_start_q;
    assign array_wr_o.addr  = wr_addr_q;
    assign busy_o           = busy;

endmodule : spi_eeprom_write_protect

// ---- verification/spi_eeprom_write_protect_monitor.sv ----
`timescale 1ns/100ps
module spi_eeprom_write_protect_monitor #(
    parameter int WRITE_CYCLES_P = 16
) (
    input  wire logic                   ref_clk_i,
    input  wire logic                   arst_n_i,
    input  wire logic                   cs_n_i,
    input  wire logic                   sck_i,
    input  wire logic                   si_i,
    input  wire logic                   wp_n_i,
    input  wire logic                   so_o,
    input  wire logic                   so_oe_o,
    input  wire eeprom_wp_pkg::status_s   status_o,
    input  wire eeprom_wp_pkg::array_wr_s array_wr_o,
    input  wire logic                   busy_o
);
    import eeprom_wp_pkg::*;

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!arst_n_i);

    // ----------
    // busy length counter
    // ----------
    int busy_cnt_q;
    int busy_cnt_d;
    always_comb begin
        busy_cnt_d = busy_o ? busy_cnt_q + 1 : 0;
    end
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            busy_cnt_q <= 0;
        end else begin
            busy_cnt_q <= busy_cnt_d;
        end
    end

    // ----------
    // assertions
    // ----------
    a_start_needs_latch:
    assert property (array_wr_o.start |-> $past(status_o.latch))
        else $error("array write began without the latch");
    a_start_clears_latch:
    assert property (array_wr_o.start |-> !status_o.latch)
        else $error("latch still set at write start");
    a_start_not_busy:
    assert property (array_wr_o.start |-> !$past(busy_o))
        else $error("write started inside a running cycle");
    a_start_then_busy:
    assert property (array_wr_o.start |=> busy_o && status_o.busy)
        else $error("busy missing after write start");
    a_busy_length:
    assert property ($fell(busy_o) |-> busy_cnt_q == WRITE_CYCLES_P)
        else $error("write cycle length wrong");
    a_unused_zero:
    assert property (status_o.unused == 3'h0)
        else $error("unused status bits not zero");
    a_sel_needs_write:
    assert property ($changed(status_o.sel)
                     |-> $past(status_o.latch) && !$past(busy_o))
        else $error("protect selects changed without a write");
    a_oe_idle_off:
    assert property (cs_n_i [*6] |-> !so_oe_o)
        else $error("serial output driven while deselected");
    a_latch_at_deselect:
    assert property ($changed(status_o.latch) |-> cs_n_i)
        else $error("latch moved while selected");
    a_start_after_deselect:
    assert property (array_wr_o.start |-> cs_n_i && $past(cs_n_i, 2))
        else $error("write started without select rise");

    cover property (array_wr_o.start);
    cover property ($fell(busy_o));
    cover property ($rose(so_oe_o));
endmodule : spi_eeprom_write_protect_monitor

bind spi_eeprom_write_protect spi_eeprom_write_protect_monitor #(
    .WRITE_CYCLES_P(WRITE_CYCLES_P)
) u_spi_eeprom_write_protect_monitor (
    .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .cs_n_i(cs_n_i),
    .sck_i(sck_i), .si_i(si_i), .wp_n_i(wp_n_i), .so_o(so_o),
    .so_oe_o(so_oe_o), .status_o(status_o), .array_wr_o(array_wr_o),
    .busy_o(busy_o)
);

// ---- verification/spi_master_model.sv ----
`timescale 1ns/100ps
module spi_master_model (
    output logic      cs_n_o,
    output logic      sck_o,
    output logic      si_o,
    input  wire logic so_i
);
    initial begin
        cs_n_o = 1'b1;
        sck_o = 1'b0;
        si_o = 1'b0;
    end

    // tx is left aligned; bits beyond 64 are not needed by any frame
    task automatic frame(input logic [63:0] tx, input int nbits,
                         output logic [63:0] rx);
        rx = '0;
        cs_n_o = 1'b0;
        #16;
        for (int i = 63; i >= 64 - nbits; i--) begin
            si_o = tx[i];
            #16 sck_o = 1'b1;
            #16 rx = {rx[62:0], so_i};
            sck_o = 1'b0;
        end
        #16 cs_n_o = 1'b1;
        // released line: flip so a stale level is never trusted
        si_o = ~si_o;
        #40;
    endtask : frame
endmodule : spi_master_model

// ---- verification/tb_spi_eeprom_write_protect.sv ----
`timescale 1ns/100ps
`define CHK(a, e) begin \
    compares++; \
    if ((a) !== (e)) begin \
        err_total++; \
        $display("CHECK FAILED at %0t: got %h want %h", $time, a, e); \
    end \
end
module tb_spi_eeprom_write_protect;
    import eeprom_wp_pkg::*;
    localparam int WC = 500;
    localparam logic [3:0][13:0] ADDRS = {14'h3000, 14'h2FFF,
                                          14'h2000, 14'h1FFF};
    logic        ref_clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        wp_n = 1'b1;
    logic        cs_n, sck, si, so, so_oe, busy, prot;
    wire         so_pin;
    status_s     status;
    array_wr_s   array_wr;
    int          err_total = 0;
    int          compares = 0;
    int          starts = 0;
    int          n0;
    logic [63:0] rx;

    always #2 ref_clk = ~ref_clk;
    assign so_pin = so_oe ? so : 1'bz;
    always @(negedge ref_clk) if (array_wr.start === 1'b1) starts++;

    spi_eeprom_write_protect #(
        .WRITE_CYCLES_P(WC)
    ) u_spi_eeprom_write_protect (
        .ref_clk_i(ref_clk), .arst_n_i(arst_n), .cs_n_i(cs_n),
        .sck_i(sck), .si_i(si), .wp_n_i(wp_n), .so_o(so),
        .so_oe_o(so_oe), .status_o(status), .array_wr_o(array_wr),
        .busy_o(busy)
    );
    spi_master_model u_spi_master_model (
        .cs_n_o(cs_n), .sck_o(sck), .si_o(si), .so_i(so_pin)
    );

    // ----------
    // access tasks
    // ----------
    task automatic op(input logic [7:0] code, input int n);
        u_spi_master_model.frame({code, 56'h0}, n, rx);
    endtask : op
    task automatic wait_idle();
        int k;
        k = 0;
        while (busy !== 1'b0 && k < 4000) begin
            @(posedge ref_clk);
            #1 k++;
        end
        if (k >= 4000) begin
            err_total++;
            $display("CHECK FAILED at %0t: write cycle never ended", $time);
            give_verdict();
        end
    endtask : wait_idle
    task automatic wr_status(input logic [7:0] d, input int n);
        op(OP_SET_LATCH, 8);
        u_spi_master_model.frame({OP_STATUS_WRITE, d, 48'h0}, n, rx);
        wait_idle();
    endtask : wr_status
    task automatic arr_wr(input logic [13:0] a, input int n);
        op(OP_SET_LATCH, 8);
        u_spi_master_model.frame({OP_ARRAY_WRITE, 2'h0, a, 40'hA5}, n, rx);
        wait_idle();
    endtask : arr_wr
    task automatic rd_status(input logic [7:0] e);
        op(OP_STATUS_READ, 24);
        `CHK(rx[15:0], {e, e})
    endtask : rd_status
    task automatic set_wp(input logic v);
        @(posedge ref_clk);
        #1 wp_n = v;
    endtask : set_wp
    task automatic give_verdict();
        $display("compares %0d errors %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : give_verdict

    // ----------
    // tests
    // ----------
    initial begin
        repeat (12) @(posedge ref_clk);
        #1 arst_n = 1'b1;
        repeat (4) @(posedge ref_clk);
        #1;
        `CHK(status, 8'h00)
        `CHK(so_oe, 1'b0)
        rd_status(8'h00);
        op(OP_SET_LATCH, 9);
        rd_status(8'h00);
        op(OP_SET_LATCH, 8);
        rd_status(8'h02);
        `CHK(so_oe, 1'b0)
        op(OP_CLEAR_LATCH, 8);
        rd_status(8'h00);
        u_spi_master_model.frame({OP_STATUS_WRITE, 8'h0C, 48'h0}, 16, rx);
        `CHK(status, 8'h00)
        wr_status(8'h0C, 17);
        `CHK(status, 8'h02)
        op(OP_SET_LATCH, 8);
        u_spi_master_model.frame({OP_STATUS_WRITE, 8'hFF, 48'h0}, 16, rx);
        `CHK(busy, 1'b1)
        rd_status(8'h8D);
        wait_idle();
        rd_status(8'h8C);
        set_wp(1'b0);
        wr_status(8'h00, 16);
        `CHK(status, 8'h8E)
        set_wp(1'b1);
        wr_status(8'h80, 16);
        `CHK(status, 8'h80)
        set_wp(1'b0);
        n0 = starts;
        arr_wr(14'h3000, 32);
        `CHK(starts - n0, 1)
        set_wp(1'b1);
        op(OP_SET_LATCH, 8);
        u_spi_master_model.frame({OP_STATUS_WRITE, 8'h88, 48'h0}, 16, rx);
        set_wp(1'b0);
        `CHK(busy, 1'b1)
        wait_idle();
        `CHK(status, 8'h88)
        set_wp(1'b1);
        for (int s = 0; s < 4; s++) begin
            wr_status({4'h0, s[1:0], 2'h0}, 16);
            for (int j = 0; j < 4; j++) begin
                prot = !(s == 0 || (s == 1 && j < 3) || (s == 2 && j == 0));
                n0 = starts;
                arr_wr(ADDRS[j], 40);
                `CHK(starts - n0, int'(!prot))
                `CHK(status.latch, prot)
                if (!prot) `CHK(array_wr.addr, ADDRS[j])
            end
        end
        wr_status(8'h00, 16);
        n0 = starts;
        arr_wr(14'h0100, 36);
        `CHK(starts - n0, 0)
        op(OP_SET_LATCH, 8);
        u_spi_master_model.frame({OP_ARRAY_WRITE, 56'h0}, 32, rx);
        op(OP_SET_LATCH, 8);
        u_spi_master_model.frame({OP_ARRAY_WRITE, 56'h0}, 32, rx);
        wait_idle();
        `CHK(starts - n0, 1)
        `CHK(status, 8'h02)
        give_verdict();
    end

    initial begin
        #200000;
        err_total++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        give_verdict();
    end
endmodule : tb_spi_eeprom_write_protect
